//--- camsb_mem.sv
// Search memory end: storage, masked compare, encoded and two-cycle one-hot output
`timescale 1ns/1ns
`default_nettype none
module camsb_mem #(
  parameter logic [1023:0] INIT_DATA = '0, // Preloaded words, word i at bits 32i+31:32i
  parameter logic [1023:0] INIT_CARE = '1 // Preloaded care masks, 1 means compared
) (
  input wire logic clk, // Clock, 100 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  camsb_if.mem bus // Link to user logic
);
  // Write counter, output stage and compare results
  logic [1:0] wcnt_q, wcnt_d;
  camsb_pkg::camsb_out_e st_q, st_d;
  logic [31:0] hit_q, hit_d;
  logic [4:0] maddr_q, maddr_d;
  logic found_q, found_d;
  logic [15:0] lines_q, lines_d;
  logic lvalid_q, lvalid_d;
  logic lupper_q, lupper_d;
  logic busy_q, busy_d;
  wire logic [31:0] hit_now;
  logic [4:0] enc_now;
  logic [1:0] wlen;
  logic wr_commit;

  // ----------------------------------------
  // Write sequencing
  // ----------------------------------------
  // Write commits on the last held cycle; masked writes need one more
  always_comb
  begin
    wlen = bus.wr_masked ? 2'(camsb_pkg::WR_CYCLES_MASK) : 2'(camsb_pkg::WR_CYCLES);
    wcnt_d = camsb_pkg::CNT_RST;
    wr_commit = 1'b0;
    if (bus.wr_req)
    begin
      if (wcnt_q + 2'h1 >= wlen)
      begin
        wr_commit = 1'b1;
      end
      else
      begin
        wcnt_d = wcnt_q + 2'h1;
      end
    end
  end

  // Write counter register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wcnt_q <= camsb_pkg::CNT_RST;
    end
    else
    begin
      wcnt_q <= wcnt_d;
    end
  end

  // ----------------------------------------
  // Word storage and compare
  // ----------------------------------------
  // One location per block: its word, its care mask and its comparator
  for (genvar g = 0; g < camsb_pkg::WORDS; g++)
  begin : g_word
    logic [31:0] data_q, data_d;
    logic [31:0] care_q, care_d;
    // Next value: taken only on the commit cycle of a write to this index
    always_comb
    begin
      data_d = data_q;
      care_d = care_q;
      if (wr_commit && (bus.wr_addr == 5'(g)))
      begin
        data_d = bus.wr_data;
        care_d = bus.wr_masked ? bus.wr_care : camsb_pkg::CARE_ALL;
      end
    end
    // Location registers, preloaded at reset
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        data_q <= INIT_DATA[g*32 +: 32];
        care_q <= INIT_CARE[g*32 +: 32];
      end
      else
      begin
        data_q <= data_d;
        care_q <= care_d;
      end
    end
    // Only cared bits take part, so masked bits never block a hit
    assign hit_now[g] = ((data_q ^ bus.srch_data) & care_q) == camsb_pkg::WORD_RST;
  end

  // ----------------------------------------
  // Address encoder
  // ----------------------------------------
  // Lowest matching location wins when several words hit
  always_comb
  begin
    enc_now = camsb_pkg::ADDR_RST;
    for (int i = camsb_pkg::WORDS - 1; i >= 0; i--)
    begin
      if (hit_now[i])
      begin
        enc_now = 5'(i);
      end
    end
  end

  // ----------------------------------------
  // Result output
  // ----------------------------------------
  // Search result captured, then one-hot halves shown low then high
  always_comb
  begin
    st_d = camsb_pkg::CAMSB_IDLE;
    hit_d = hit_q;
    maddr_d = maddr_q;
    found_d = found_q;
    lines_d = camsb_pkg::LINES_RST;
    lvalid_d = 1'b0;
    lupper_d = 1'b0;
    unique case (st_q)
      camsb_pkg::CAMSB_HALF0:
      begin
        lines_d = hit_q[31:16];
        lvalid_d = 1'b1;
        lupper_d = 1'b1;
        st_d = camsb_pkg::CAMSB_HALF1;
      end
      camsb_pkg::CAMSB_IDLE, camsb_pkg::CAMSB_HALF1:
      begin
        if (bus.srch_req)
        begin
          hit_d = hit_now;
          found_d = |hit_now;
          maddr_d = enc_now;
          if (!bus.enc_sel)
          begin
            lines_d = hit_now[15:0];
            lvalid_d = 1'b1;
            st_d = camsb_pkg::CAMSB_HALF0;
          end
        end
      end
      default:
      begin
        st_d = camsb_pkg::CAMSB_IDLE;
      end
    endcase
    busy_d = (st_d == camsb_pkg::CAMSB_HALF0);
  end

  // Output registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= camsb_pkg::CAMSB_IDLE;
      hit_q <= camsb_pkg::WORD_RST;
      maddr_q <= camsb_pkg::ADDR_RST;
      found_q <= 1'b0;
      lines_q <= camsb_pkg::LINES_RST;
      lvalid_q <= 1'b0;
      lupper_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      hit_q <= hit_d;
      maddr_q <= maddr_d;
      found_q <= found_d;
      lines_q <= lines_d;
      lvalid_q <= lvalid_d;
      lupper_q <= lupper_d;
      busy_q <= busy_d;
    end
  end

  // Outputs, each straight from its register
  assign bus.match_addr = maddr_q;
  assign bus.match_found = found_q;
  assign bus.match_lines = lines_q;
  assign bus.lines_valid = lvalid_q;
  assign bus.lines_upper = lupper_q;
  assign bus.busy = busy_q;
endmodule : camsb_mem
`default_nettype wire

//--- camsb_pkg.sv
// Shared constants and types for the search memory and its user-side writer
package camsb_pkg;
  localparam int WORDS = 32;
  localparam int WIDTH = 32;
  localparam int ADDR_W = 5;
  localparam int LINES = 16;
  localparam int WR_CYCLES = 2;
  localparam int WR_CYCLES_MASK = 3;
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [4:0] ADDR_RST = 5'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [31:0] CARE_ALL = 32'hffff_ffff;
  localparam logic [15:0] LINES_RST = 16'h0000;
  typedef enum logic [1:0] {CAMSB_IDLE = 2'b00, CAMSB_HALF0 = 2'b01, CAMSB_HALF1 = 2'b11} camsb_out_e;
endpackage : camsb_pkg

//--- camsb_if.sv
// Interface joining the user-side logic to the search memory
`timescale 1ns/1ns
`default_nettype none
interface camsb_if;
  logic wr_req;
  logic [4:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] wr_care;
  logic wr_masked;
  logic srch_req;
  logic [31:0] srch_data;
  logic enc_sel;
  logic [4:0] match_addr;
  logic match_found;
  logic [15:0] match_lines;
  logic lines_valid;
  logic lines_upper;
  logic busy;
  modport mem (input wr_req, wr_addr, wr_data, wr_care, wr_masked, srch_req, srch_data, enc_sel,
               output match_addr, match_found, match_lines, lines_valid, lines_upper, busy);
  modport user (output wr_req, wr_addr, wr_data, wr_care, wr_masked, srch_req, srch_data, enc_sel,
                input match_addr, match_found, match_lines, lines_valid, lines_upper, busy);
endinterface : camsb_if
`default_nettype wire

//--- camsb_user.sv
// User-side end: holds writes for their full length, issues searches, gathers results
`timescale 1ns/1ns
`default_nettype none
module camsb_user (
  input wire logic clk, // Clock, 100 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic cmd_wr, // Pulse: start a write
  input wire logic [4:0] cmd_addr, // Write address
  input wire logic [31:0] cmd_data, // Write data
  input wire logic [31:0] cmd_care, // Care mask, 1 means compared
  input wire logic cmd_masked, // Write uses masked bits
  input wire logic cmd_srch, // Pulse: start a search
  input wire logic [31:0] cmd_key, // Search data
  input wire logic cmd_enc, // 1 encoded, 0 one-hot
  output logic ready, // Able to take a command
  output logic res_valid, // Pulse: result ready
  output logic [31:0] res_vector, // All matching locations
  output logic [4:0] res_addr, // Encoded address
  output logic res_found, // Any match
  camsb_if.user bus // Link to memory
);
  logic [1:0] cnt_q, cnt_d;
  logic act_q, act_d;
  logic [1:0] len_q, len_d;
  logic wr_q, wr_d, sr_q, sr_d, enc_q, enc_d, msk_q, msk_d;
  logic [4:0] a_q, a_d;
  logic [31:0] dat_q, dat_d, care_q, care_d, key_q, key_d;
  logic [1:0] wait_q, wait_d;
  logic [15:0] lo_q, lo_d;
  logic rv_q, rv_d, rf_q, rf_d;
  logic [31:0] vec_q, vec_d;
  logic [4:0] ra_q, ra_d;
  logic rdy_q, rdy_d;

  // Command sequencing, result gathering over both halves in one-hot form, one cycle in encoded form
  always_comb
  begin
    {act_d, cnt_d, len_d, wr_d, sr_d, enc_d, msk_d} = {act_q, cnt_q, len_q, wr_q, sr_q, enc_q, msk_q};
    {a_d, dat_d, care_d, key_d, wait_d, lo_d} = {a_q, dat_q, care_q, key_q, wait_q, lo_q};
    {vec_d, ra_d, rf_d} = {vec_q, ra_q, rf_q};
    rv_d = 1'b0;
    sr_d = 1'b0;
    if (wr_q)
    begin
      if (cnt_q + 2'h1 >= len_q)
      begin
        wr_d = 1'b0;
        act_d = 1'b0;
      end
      cnt_d = cnt_q + 2'h1;
    end
    else if (wait_q != camsb_pkg::CNT_RST)
    begin
      wait_d = wait_q - 2'h1;
      if (wait_q == 2'h1 && bus.enc_sel)
      begin
        ra_d = bus.match_addr;
        rf_d = bus.match_found;
        rv_d = 1'b1;
        act_d = 1'b0;
      end
      else if (bus.lines_valid && !bus.lines_upper)
      begin
        lo_d = bus.match_lines;
        rf_d = bus.match_found;
        ra_d = bus.match_addr;
      end
      else if (bus.lines_valid && bus.lines_upper)
      begin
        vec_d = {bus.match_lines, lo_q};
        rv_d = 1'b1;
        act_d = 1'b0;
        wait_d = camsb_pkg::CNT_RST;
      end
    end
    else if (!act_q && cmd_wr)
    begin
      {act_d, wr_d, cnt_d, a_d, dat_d, care_d, msk_d} = {2'b11, camsb_pkg::CNT_RST, cmd_addr, cmd_data,
                                                          cmd_care, cmd_masked};
      len_d = cmd_masked ? 2'(camsb_pkg::WR_CYCLES_MASK) : 2'(camsb_pkg::WR_CYCLES);
    end
    else if (!act_q && cmd_srch)
    begin
      {act_d, sr_d, key_d, enc_d} = {2'b11, cmd_key, cmd_enc};
      wait_d = cmd_enc ? 2'h2 : 2'h3;
    end
    rdy_d = !act_d;
  end

  // Register stage for all user-side state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {act_q, wr_q, sr_q, enc_q, msk_q, rv_q, rf_q} <= 7'h00;
      {cnt_q, len_q, wait_q} <= 6'h00;
      {a_q, ra_q} <= 10'h000;
      {dat_q, care_q, key_q, vec_q} <= 128'h0;
      lo_q <= camsb_pkg::LINES_RST;
      rdy_q <= 1'b1;
    end
    else
    begin
      {act_q, wr_q, sr_q, enc_q, msk_q, rv_q, rf_q} <= {act_d, wr_d, sr_d, enc_d, msk_d, rv_d, rf_d};
      {cnt_q, len_q, wait_q} <= {cnt_d, len_d, wait_d};
      {a_q, ra_q} <= {a_d, ra_d};
      {dat_q, care_q, key_q, vec_q} <= {dat_d, care_d, key_d, vec_d};
      lo_q <= lo_d;
      rdy_q <= rdy_d;
    end
  end

  assign bus.wr_req = wr_q;
  assign bus.wr_addr = a_q;
  assign bus.wr_data = dat_q;
  assign bus.wr_care = care_q;
  assign bus.wr_masked = msk_q;
  assign bus.srch_req = sr_q;
  assign bus.srch_data = key_q;
  assign bus.enc_sel = enc_q;
  assign ready = rdy_q;
  assign res_valid = rv_q;
  assign res_vector = vec_q;
  assign res_addr = ra_q;
  assign res_found = rf_q;
endmodule : camsb_user
`default_nettype wire

//--- camsb_sva.sv
// Checker on the link between the search memory and its user end
`timescale 1ns/1ns
`default_nettype none
module camsb_sva (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic wr_req, // Write request
  input wire logic wr_masked, // Masked write
  input wire logic srch_req, // Search request
  input wire logic enc_sel, // Output form
  input wire logic busy, // Upper half pending
  input wire logic match_found, // Any match
  input wire logic [15:0] match_lines, // One-hot half
  input wire logic lines_valid, // Half valid
  input wire logic lines_upper // Upper half flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------
  // Write length and search output
  // ------------------------------
  property p_wr_plain; $rose(wr_req) && !wr_masked |-> wr_req[*2] ##1 !wr_req; endproperty
  a_wr_plain: assert property (p_wr_plain) else $error("plain write not held two cycles");
  property p_wr_mask; $rose(wr_req) && wr_masked |-> wr_req[*3] ##1 !wr_req; endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("masked write not held three cycles");
  property p_hot_start; srch_req && !busy && !enc_sel |=> lines_valid && !lines_upper; endproperty
  a_hot_start: assert property (p_hot_start) else $error("lower half missing");
  property p_enc_quiet; srch_req && !busy && enc_sel |=> !lines_valid; endproperty
  a_enc_quiet: assert property (p_enc_quiet) else $error("lines shown in encoded form");
  property p_halves; lines_valid && !lines_upper |=> lines_valid && lines_upper; endproperty
  a_halves: assert property (p_halves) else $error("upper half missing");
  property p_upper; lines_valid && lines_upper |-> $past(lines_valid) && !$past(lines_upper); endproperty
  a_upper: assert property (p_upper) else $error("upper half without lower half");
  property p_found; lines_valid && (match_lines != 16'h0000) |-> match_found; endproperty
  a_found: assert property (p_found) else $error("line high without found flag");
  property p_none;
    lines_valid && lines_upper && !match_found |-> match_lines == 16'h0000 && $past(match_lines) == 16'h0000;
  endproperty
  a_none: assert property (p_none) else $error("lines high without match");
endmodule : camsb_sva
`default_nettype wire

//--- tb_top.sv
// Testbench joining both ends and comparing results with a reference model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [1023:0] PRE = {16{32'h1234_5678, 32'h0bad_cafe}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_wr = 1'b0, cmd_masked = 1'b0, cmd_srch = 1'b0, cmd_enc = 1'b0;
  logic [4:0] cmd_addr = 5'h00;
  logic [31:0] cmd_data = 32'h0000_0000, cmd_care = 32'h0000_0000, cmd_key = 32'h0000_0000;
  logic ready, res_valid, res_found;
  logic [31:0] res_vector;
  logic [4:0] res_addr;
  logic [31:0] mdat [32];
  logic [31:0] mcare [32];
  int num_errors = 0, check_count = 0, cycles = 0, seed = 32'h8574;
  camsb_if bus ();
  camsb_mem #(.INIT_DATA(PRE)) camsb_mem_inst (.clk(clk), .rst_n(rst_n), .bus(bus));
  camsb_user camsb_user_inst (.clk(clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_care(cmd_care), .cmd_masked(cmd_masked), .cmd_srch(cmd_srch), .cmd_key(cmd_key),
    .cmd_enc(cmd_enc), .ready(ready), .res_valid(res_valid), .res_vector(res_vector), .res_addr(res_addr),
    .res_found(res_found), .bus(bus));
  camsb_sva camsb_sva_inst (.clk(clk), .rst_n(rst_n), .wr_req(bus.wr_req), .wr_masked(bus.wr_masked),
    .srch_req(bus.srch_req), .enc_sel(bus.enc_sel), .busy(bus.busy), .match_found(bus.match_found),
    .match_lines(bus.match_lines), .lines_valid(bus.lines_valid), .lines_upper(bus.lines_upper));
  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  // Compare one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Write one word and update the model
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [31:0] c, input logic m);
    while (!ready) @(negedge clk);
    cmd_wr = 1'b1;
    cmd_addr = a;
    cmd_data = d;
    cmd_care = c;
    cmd_masked = m;
    @(negedge clk);
    cmd_wr = 1'b0;
    mdat[a] = d;
    mcare[a] = m ? c : 32'hffff_ffff;
  endtask : wr
  // Search and check against the model
  task automatic srch(input logic [31:0] k, input logic e);
    int n;
    logic [31:0] v;
    logic [4:0] a;
    logic enc;
    a = 5'h00;
    for (int i = 31; i >= 0; i--)
    begin
      v[i] = ((mdat[i] ^ k) & mcare[i]) == 32'h0000_0000;
      if (v[i]) a = 5'(i);
    end
    enc = e && ($countones(v) < 2);
    while (!ready) @(negedge clk);
    cmd_srch = 1'b1;
    cmd_key = k;
    cmd_enc = enc;
    @(negedge clk);
    cmd_srch = 1'b0;
    n = 1;
    while (!res_valid && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    chk("latency", enc ? 32'h0000_0003 : 32'h0000_0004, 32'(n));
    chk("found", {31'h0000_0000, |v}, {31'h0000_0000, res_found});
    if (enc) chk("address", {27'h000_0000, a}, {27'h000_0000, res_addr});
    else chk("vector", v, res_vector);
  endtask : srch
  // Counts and verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial
  begin
    logic [31:0] r1, r2, r3;
    for (int i = 0; i < 32; i++)
    begin
      mdat[i] = PRE[32*i +: 32];
      mcare[i] = 32'hffff_ffff;
    end
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    srch(32'h0bad_cafe, 1'b0);
    srch(32'h1234_5678, 1'b1);
    $display("test preload done");
    wr(5'h1f, 32'hc0de_0031, 32'h0000_0000, 1'b0);
    srch(32'hc0de_0031, 1'b1);
    srch(32'hc0de_0031, 1'b0);
    wr(5'h10, 32'h5a5a_0000, 32'hffff_0000, 1'b1);
    srch(32'h5a5a_7777, 1'b0);
    srch(32'hdead_beef, 1'b1);
    srch(32'hdead_beef, 1'b0);
    $display("test write done");
    repeat (40)
    begin
      r1 = $random(seed);
      r2 = $random(seed);
      r3 = $random(seed);
      wr(r1[4:0], r2, r3, r1[5]);
      srch(mdat[r1[9:5]] ^ (r3 & ~mcare[r1[9:5]]), r1[10]);
    end
    $display("test random done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
